//--- sfb_pkg.sv
// Constants, types and opcode decoding for the serial flash front end.
// Assumes a 125 MHz system clock; the serial clock comes from the host.
package sfb_pkg;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_DTR_FAST = 8'h0D;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_DUAL_IO = 8'hBB;
	localparam logic [7:0] OP_DTR_DUAL = 8'hBD;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_QUAD_IO = 8'hEB;
	localparam logic [7:0] OP_DTR_QUAD = 8'hED;
	localparam logic [7:0] OP_QUAD_PROG = 8'h32;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR1 = 8'h05;
	localparam logic [7:0] OP_RDSR2 = 8'h35;
	localparam logic [7:0] OP_RDSR3 = 8'h15;
	localparam logic [7:0] OP_WRSR1 = 8'h01;
	localparam logic [7:0] OP_WRSR2 = 8'h31;
	localparam logic [7:0] OP_WRSR3 = 8'h11;
	localparam logic [7:0] OP_SECT_ERASE = 8'h20;
	localparam logic [7:0] OP_BLK_ERASE = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE2 = 8'hC7;
	localparam logic [7:0] OP_QPI_ON = 8'h38;
	localparam logic [7:0] OP_QPI_OFF = 8'hFF;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	localparam logic [7:0] OP_RDID = 8'h9F;
	localparam logic [4:0] OP_BITS = 5'h08;
	localparam logic [4:0] ADDR_BITS = 5'h18;
	localparam logic [4:0] DUMMY_FAST = 5'h08;
	localparam logic [4:0] DUMMY_DUAL_IO = 5'h04;
	localparam logic [4:0] DUMMY_QUAD_IO = 5'h06;
	localparam logic [7:0] TX_IDLE = 8'hFF;
	localparam logic [4:0] SYNC_RST = 5'h18;
	localparam int CLK_MHZ = 125;
	localparam int RST_PULSE_MIN_NS = 1000;
	localparam int RST_PULSE_CYC = (RST_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [4:0] {
		ST_CMD = 5'h01, ST_ADDR = 5'h02, ST_DUMMY = 5'h04,
		ST_DATA = 5'h08, ST_IGNORE = 5'h10
	} sfb_state_e;
	typedef enum logic [1:0] {
		RX_OPCODE = 2'h0, RX_ADDR = 2'h1, RX_DATA = 2'h2
	} sfb_rx_kind_e;
	typedef struct packed {
		sfb_rx_kind_e kind;
		logic [23:0] value;
	} sfb_rx_s;

	function automatic logic op_known(input logic [7:0] op, input logic qe);
		case (op)
			OP_QUAD_OUT, OP_QUAD_IO, OP_DTR_QUAD, OP_QUAD_PROG,
			OP_QPI_ON: op_known = qe;
			OP_READ, OP_FAST, OP_DTR_FAST, OP_DUAL_OUT, OP_DUAL_IO,
			OP_DTR_DUAL, OP_PROG, OP_WREN, OP_WRDI, OP_RDSR1, OP_RDSR2,
			OP_RDSR3, OP_WRSR1, OP_WRSR2, OP_WRSR3, OP_SECT_ERASE,
			OP_BLK_ERASE, OP_CHIP_ERASE, OP_CHIP_ERASE2, OP_QPI_OFF,
			OP_RST_EN, OP_RST, OP_RDID: op_known = 1'b1;
			default: op_known = 1'b0;
		endcase
	endfunction : op_known

	function automatic logic op_has_addr(input logic [7:0] op);
		case (op)
			OP_READ, OP_FAST, OP_DTR_FAST, OP_DUAL_OUT, OP_DUAL_IO,
			OP_DTR_DUAL, OP_QUAD_OUT, OP_QUAD_IO, OP_DTR_QUAD,
			OP_QUAD_PROG, OP_PROG, OP_SECT_ERASE,
			OP_BLK_ERASE: op_has_addr = 1'b1;
			default: op_has_addr = 1'b0;
		endcase
	endfunction : op_has_addr

	function automatic logic op_read(input logic [7:0] op);
		case (op)
			OP_READ, OP_FAST, OP_DTR_FAST, OP_DUAL_OUT, OP_DUAL_IO,
			OP_DTR_DUAL, OP_QUAD_OUT, OP_QUAD_IO, OP_DTR_QUAD, OP_RDSR1,
			OP_RDSR2, OP_RDSR3, OP_RDID: op_read = 1'b1;
			default: op_read = 1'b0;
		endcase
	endfunction : op_read

	function automatic logic op_write(input logic [7:0] op);
		op_write = op == OP_PROG || op == OP_QUAD_PROG || op == OP_WRSR1
			|| op == OP_WRSR2 || op == OP_WRSR3;
	endfunction : op_write

	function automatic logic op_dtr(input logic [7:0] op);
		op_dtr = op == OP_DTR_FAST || op == OP_DTR_DUAL || op == OP_DTR_QUAD;
	endfunction : op_dtr

	function automatic logic [4:0] op_dummy(input logic [7:0] op);
		case (op)
			OP_FAST, OP_DTR_FAST, OP_DUAL_OUT,
			OP_QUAD_OUT: op_dummy = DUMMY_FAST;
			OP_DUAL_IO, OP_DTR_DUAL: op_dummy = DUMMY_DUAL_IO;
			OP_QUAD_IO, OP_DTR_QUAD: op_dummy = DUMMY_QUAD_IO;
			default: op_dummy = 5'h00;
		endcase
	endfunction : op_dummy

	function automatic logic [2:0] op_lanes(input logic [7:0] op,
		input logic four_line_command_mode, input logic addr);
		if (four_line_command_mode)
			op_lanes = 3'h4;
		else if (op == OP_DUAL_IO || op == OP_DTR_DUAL)
			op_lanes = 3'h2;
		else if (op == OP_QUAD_IO || op == OP_DTR_QUAD)
			op_lanes = 3'h4;
		else if (!addr && op == OP_DUAL_OUT)
			op_lanes = 3'h2;
		else if (!addr && (op == OP_QUAD_OUT || op == OP_QUAD_PROG))
			op_lanes = 3'h4;
		else
			op_lanes = 3'h1;
	endfunction : op_lanes
endpackage : sfb_pkg

//--- sfb_front_end.sv
// Serial flash bus front end: frame decode, lane widening, pause, reset.
// Assumes i_sclk comes from the host and may stop outside frames.
`timescale 1ns/1ns
module sfb_front_end #(
	parameter int RST_CYC = sfb_pkg::RST_PULSE_CYC
) (
	input wire logic i_clk_sys, // System clock.
	input wire logic i_rstn, // Asynchronous reset, active low.
	input wire logic i_sclk, // Serial clock from the host.
	input wire logic i_cs_n, // Chip select, active low.
	input wire logic [3:0] i_io_in, // Levels of data_line_3..0.
	output logic [3:0] o_io_out, // Drive values of data_line_3..0.
	output logic [3:0] o_io_oe, // Drive enables of data_line_3..0.
	input wire logic i_rst_pin_n, // Dedicated reset pin, active low.
	input wire logic i_quad_enable_bit, // Quad enable setting.
	input wire logic i_pin_func_sel, // Shared pin: 1 reset, 0 pause.
	input wire logic [7:0] i_tx_byte, // Next read data byte.
	input wire logic i_tx_valid, // Read data byte offered.
	output logic o_tx_ready, // Read data holding slot free.
	output sfb_pkg::sfb_rx_s o_rx, // Last received item.
	output logic o_rx_valid, // Pulse: o_rx holds a new item.
	output logic o_four_line_command_mode, // Mode flag, synchronised.
	output logic o_hw_reset // Pin reset in force.
);
	sfb_pkg::sfb_state_e st_r;
	logic [4:0] cnt_r;
	logic [23:0] sh_r;
	logic [7:0] op_r;
	logic dtr_go_r;
	logic [3:0] pos_io_r;
	logic [3:0] neg_io_r;
	logic qpi_r, qe_m_r, qe_r, sel_m_r, sel_r;
	sfb_pkg::sfb_rx_s rx_r;
	logic rx_tgl_r;
	logic [7:0] tx_sh_r;
	logic [3:0] tx_cnt_r;
	logic [3:0] n_r, p_r, b_r;
	logic txs_m_r, txs_r, ack_r;
	logic [7:0] tx_hold_r;
	logic tx_tgl_r;
	logic [4:0] sy_m_r, sy_r;
	logic rx_p_r;
	logic [15:0] rcnt_r;
	logic hw_rst_r;
	logic lrst_n, qrst_n;
	logic [2:0] lanes;
	logic hold_en, ign;
	logic [4:0] cnt_add, a_cnt;
	logic [23:0] sh_in, a_sh;
	logic op_done, addr_done, byte_done, known;
	logic [7:0] op_in;
	logic drive, dtr, fresh, tx_load;
	logic [2:0] dl;
	logic [3:0] step;
	logic [7:0] cur;

	function automatic logic [23:0] shl(input logic [23:0] s,
		input logic [3:0] d, input logic [2:0] l);
		case (l)
			3'h4: shl = {s[19:0], d};
			3'h2: shl = {s[21:0], d[1:0]};
			default: shl = {s[22:0], d[0]};
		endcase
	endfunction : shl

	// Single lane reads leave on data_line_1, dual ones on data_line_1..0, quad ones on all four lines.
	function automatic logic [3:0] lane_out(input logic [7:0] v,
		input logic [2:0] l);
		case (l)
			3'h4: lane_out = v[7:4];
			3'h2: lane_out = {2'h0, v[7:6]};
			default: lane_out = {2'h0, v[7], 1'h0};
		endcase
	endfunction : lane_out

	// Select high clears the frame; the reset pin also clears the mode flag and the rest of the serial clock side.
	assign qrst_n = i_rstn & ~hw_rst_r;
	assign lrst_n = qrst_n & ~i_cs_n;

	always_comb begin
		case (st_r)
			sfb_pkg::ST_CMD: lanes = qpi_r ? 3'h4 : 3'h1;
			sfb_pkg::ST_ADDR: lanes = sfb_pkg::op_lanes(op_r, qpi_r, 1'b1);
			default: lanes = sfb_pkg::op_lanes(op_r, qpi_r, 1'b0);
		endcase
	end

	// The rising edge looks at the pause pin itself, so a pause that began
	// with the clock low already blocks the next rising edge.
	assign hold_en = ~qe_r & ~sel_r & ~qpi_r & (lanes != 3'h4);
	assign ign = hold_en & ~i_io_in[3];
	assign sh_in = shl(sh_r, i_io_in, lanes);
	assign cnt_add = cnt_r + 5'(lanes);
	assign op_in = sh_in[7:0];
	assign known = sfb_pkg::op_known(op_in, qe_r);
	assign op_done = st_r == sfb_pkg::ST_CMD && cnt_add == sfb_pkg::OP_BITS
		&& !ign;
	assign dtr = sfb_pkg::op_dtr(op_r);

	always_comb begin
		a_sh = sh_in;
		a_cnt = cnt_add;
		if (dtr) begin
			a_sh = dtr_go_r ? shl(shl(sh_r, pos_io_r, lanes), neg_io_r, lanes)
				: sh_r;
			a_cnt = dtr_go_r ? cnt_r + 5'({lanes, 1'b0}) : cnt_r;
		end
	end

	assign addr_done = st_r == sfb_pkg::ST_ADDR
		&& a_cnt == sfb_pkg::ADDR_BITS && !ign;
	assign byte_done = st_r == sfb_pkg::ST_DATA && sfb_pkg::op_write(op_r)
		&& cnt_add == sfb_pkg::OP_BITS && !ign;

	always_ff @(posedge i_sclk or negedge lrst_n) begin
		if (!lrst_n) begin
			st_r <= sfb_pkg::ST_CMD;
			cnt_r <= 5'h00;
			sh_r <= 24'h000000;
			op_r <= 8'h00;
			dtr_go_r <= 1'b0;
			pos_io_r <= 4'h0;
		end else if (!ign) begin
			case (st_r)
				sfb_pkg::ST_CMD: begin
					sh_r <= sh_in;
					cnt_r <= cnt_add;
					if (op_done) begin
						cnt_r <= 5'h00;
						op_r <= op_in;
						if (!known)
							st_r <= sfb_pkg::ST_IGNORE;
						else if (sfb_pkg::op_has_addr(op_in))
							st_r <= sfb_pkg::ST_ADDR;
						else
							st_r <= sfb_pkg::ST_DATA;
					end
				end
				sfb_pkg::ST_ADDR: begin
					pos_io_r <= i_io_in;
					dtr_go_r <= 1'b1;
					sh_r <= a_sh;
					cnt_r <= a_cnt;
					if (addr_done) begin
						cnt_r <= 5'h00;
						st_r <= sfb_pkg::op_dummy(op_r) != 5'h00 ?
							sfb_pkg::ST_DUMMY : sfb_pkg::ST_DATA;
					end
				end
				sfb_pkg::ST_DUMMY: begin
					cnt_r <= cnt_r + 5'h01;
					if (cnt_r == sfb_pkg::op_dummy(op_r) - 5'h01) begin
						cnt_r <= 5'h00;
						st_r <= sfb_pkg::ST_DATA;
					end
				end
				sfb_pkg::ST_DATA: begin
					if (sfb_pkg::op_write(op_r)) begin
						sh_r <= sh_in;
						cnt_r <= byte_done ? 5'h00 : cnt_add;
					end
				end
				default: st_r <= sfb_pkg::ST_IGNORE;
			endcase
		end
	end

	// Mode flag and configuration samples survive the end of a frame.
	always_ff @(posedge i_sclk or negedge qrst_n) begin
		if (!qrst_n) begin
			qpi_r <= 1'b0;
			qe_m_r <= 1'b0;
			qe_r <= 1'b0;
			sel_m_r <= 1'b0;
			sel_r <= 1'b0;
		end else begin
			qe_m_r <= i_quad_enable_bit;
			qe_r <= qe_m_r;
			sel_m_r <= i_pin_func_sel;
			sel_r <= sel_m_r;
			if (op_done && known) begin
				if (op_in == sfb_pkg::OP_QPI_ON)
					qpi_r <= 1'b1;
				else if (op_in == sfb_pkg::OP_QPI_OFF)
					qpi_r <= 1'b0;
				else if (op_in == sfb_pkg::OP_RST)
					qpi_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_sclk or negedge qrst_n) begin
		if (!qrst_n) begin
			rx_r <= '0;
			rx_tgl_r <= 1'b0;
		end else if (op_done && known) begin
			rx_r <= {sfb_pkg::RX_OPCODE, 16'h0000, op_in};
			rx_tgl_r <= ~rx_tgl_r;
		end else if (addr_done) begin
			rx_r <= {sfb_pkg::RX_ADDR, a_sh};
			rx_tgl_r <= ~rx_tgl_r;
		end else if (byte_done) begin
			rx_r <= {sfb_pkg::RX_DATA, 16'h0000, sh_in[7:0]};
			rx_tgl_r <= ~rx_tgl_r;
		end
	end

	// Output side on the falling edge. A byte is loaded whenever the shift
	// register runs dry; an empty holding slot sends all ones rather than
	// stalling, since the host clock cannot be stopped from here.
	assign drive = st_r == sfb_pkg::ST_DATA && sfb_pkg::op_read(op_r)
		&& !ign;
	assign dl = lanes;
	assign step = dtr ? {dl, 1'b0} : {1'b0, dl};
	assign fresh = txs_r != ack_r;
	assign tx_load = drive && tx_cnt_r == 4'h0;
	assign cur = tx_load ? (fresh ? tx_hold_r : sfb_pkg::TX_IDLE) : tx_sh_r;

	always_ff @(negedge i_sclk or negedge lrst_n) begin
		if (!lrst_n) begin
			neg_io_r <= 4'h0;
			tx_sh_r <= 8'h00;
			tx_cnt_r <= 4'h0;
			n_r <= 4'h0;
			b_r <= 4'h0;
			o_io_oe <= 4'h0;
		end else begin
			neg_io_r <= i_io_in;
			n_r <= p_r;
			o_io_oe <= 4'h0;
			if (drive) begin
				n_r <= lane_out(cur, dl) ^ p_r;
				b_r <= lane_out(8'(cur << dl), dl);
				tx_sh_r <= 8'(cur << step);
				tx_cnt_r <= (tx_load ? 4'h8 : tx_cnt_r) - step;
				case (dl)
					3'h4: o_io_oe <= 4'hF;
					3'h2: o_io_oe <= 4'h3;
					default: o_io_oe <= 4'h2;
				endcase
			end
		end
	end

	// Double-rate data: the rising edge flips the pin to the second chunk.
	always_ff @(posedge i_sclk or negedge lrst_n) begin
		if (!lrst_n)
			p_r <= 4'h0;
		else if (dtr && st_r == sfb_pkg::ST_DATA && o_io_oe != 4'h0)
			p_r <= b_r ^ n_r;
	end

	assign o_io_out = p_r ^ n_r;

	always_ff @(negedge i_sclk or negedge qrst_n) begin
		if (!qrst_n) begin
			txs_m_r <= 1'b0;
			txs_r <= 1'b0;
			ack_r <= 1'b0;
		end else begin
			txs_m_r <= tx_tgl_r;
			txs_r <= txs_m_r;
			if (tx_load && fresh)
				ack_r <= ~ack_r;
		end
	end

	// System side: pins, mode flag and toggles pass two flip-flops first.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			sy_m_r <= sfb_pkg::SYNC_RST;
			sy_r <= sfb_pkg::SYNC_RST;
			rx_p_r <= 1'b0;
		end else begin
			sy_m_r <= {i_io_in[3], i_rst_pin_n, rx_tgl_r, qpi_r, ack_r};
			sy_r <= sy_m_r;
			rx_p_r <= sy_r[2];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rx <= '0;
			o_rx_valid <= 1'b0;
			o_four_line_command_mode <= 1'b0;
		end else begin
			o_rx_valid <= sy_r[2] ^ rx_p_r;
			if (sy_r[2] ^ rx_p_r)
				o_rx <= rx_r;
			o_four_line_command_mode <= sy_r[1];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_hold_r <= 8'h00;
			tx_tgl_r <= 1'b0;
			o_tx_ready <= 1'b0;
		end else if (i_tx_valid && o_tx_ready) begin
			tx_hold_r <= i_tx_byte;
			tx_tgl_r <= ~tx_tgl_r;
			o_tx_ready <= 1'b0;
		end else begin
			o_tx_ready <= tx_tgl_r == sy_r[0];
		end
	end

	// A pulse shorter than the minimum is ignored as a glitch.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rcnt_r <= 16'h0000;
			hw_rst_r <= 1'b0;
		end else if (sy_r[3] && !(i_pin_func_sel && !i_quad_enable_bit
			&& !sy_r[4])) begin
			rcnt_r <= 16'h0000;
			hw_rst_r <= 1'b0;
		end else if (rcnt_r == 16'(RST_CYC - 1)) begin
			hw_rst_r <= 1'b1;
		end else begin
			rcnt_r <= rcnt_r + 16'h0001;
		end
	end

	assign o_hw_reset = hw_rst_r;
endmodule : sfb_front_end

//--- sfb_front_end_monitor.sv
// Checker for the serial flash front end, bound to its top module.
// Assumes every watched relation can be judged on the system clock.
`timescale 1ns/1ns
module sfb_front_end_monitor #(
	parameter int RST_CYC = sfb_pkg::RST_PULSE_CYC
) (
	input wire logic i_clk_sys, // System clock.
	input wire logic i_rstn, // Reset, active low.
	input wire logic i_cs_n, // Chip select, active low.
	input wire logic [3:0] i_io_in, // Line levels.
	input wire logic i_rst_pin_n, // Dedicated reset pin, active low.
	input wire logic i_quad_enable_bit, // Quad enable.
	input wire logic i_pin_func_sel, // Shared pin function.
	input wire logic [3:0] o_io_oe, // Drive enables.
	input wire logic o_rx_valid, // Item pulse.
	input wire logic o_four_line_command_mode, // Mode flag.
	input wire logic o_hw_reset // Pin reset in force.
);
	logic rst_req;
	int low_cnt_r;

	default clocking mon_cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);

	// Raw pin request, counted before the design's synchroniser.
	assign rst_req = !i_rst_pin_n
		|| (!i_io_in[3] && i_pin_func_sel && !i_quad_enable_bit);

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn)
			low_cnt_r <= 0;
		else if (!rst_req)
			low_cnt_r <= 0;
		else if (low_cnt_r < 1000)
			low_cnt_r <= low_cnt_r + 1;
	end

	sel_release_a: assert property (i_cs_n |-> o_io_oe == 4'h0)
		else $error("lines driven while deselected");
	lane_set_a: assert property (o_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("unexpected lane enable pattern");
	quad_gate_a: assert property (!i_quad_enable_bit
		&& !o_four_line_command_mode |-> o_io_oe[3:2] == 2'h0)
		else $error("upper lines driven without quad enable");
	mode_entry_a: assert property ($rose(o_four_line_command_mode)
		|-> i_quad_enable_bit)
		else $error("four-line mode entered without quad enable");
	rx_pulse_a: assert property (o_rx_valid |=> !o_rx_valid [*3])
		else $error("received items too close together");
	reset_min_a: assert property ($rose(o_hw_reset)
		|-> low_cnt_r >= RST_CYC)
		else $error("pin reset taken from a short pulse");
	reset_due_a: assert property (low_cnt_r >= RST_CYC + 6
		|-> o_hw_reset)
		else $error("pin reset not applied");
	reset_end_a: assert property (!rst_req [*5] |-> !o_hw_reset)
		else $error("pin reset outlasts the pin");
	mode_clear_a: assert property (o_hw_reset [*4]
		|-> !o_four_line_command_mode)
		else $error("four-line mode survives pin reset");
endmodule : sfb_front_end_monitor

bind sfb_front_end sfb_front_end_monitor #(.RST_CYC(RST_CYC))
	sfb_front_end_monitor_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
	.i_cs_n(i_cs_n), .i_io_in(i_io_in), .i_rst_pin_n(i_rst_pin_n),
	.i_quad_enable_bit(i_quad_enable_bit), .i_pin_func_sel(i_pin_func_sel),
	.o_io_oe(o_io_oe), .o_rx_valid(o_rx_valid),
	.o_four_line_command_mode(o_four_line_command_mode),
	.o_hw_reset(o_hw_reset));

//--- sfb_host_model.sv
// Host flash controller model: frames, serial clock and host line drive.
// Assumes the bench resolves each line from the device drive enables.
`timescale 1ns/1ns
module sfb_host_model (
	output logic o_sclk, // Serial clock, runs only within frames.
	output logic o_cs_n, // Chip select, active low.
	output logic [3:0] o_io, // Host drive; bit 3 doubles as pause pin.
	input wire logic [3:0] i_io // Resolved line levels.
);
	logic idle_hi;
	logic [7:0] rd_byte;

	initial begin
		idle_hi = 1'b0;
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_io = 4'hF;
		rd_byte = 8'h00;
	end

	// Unused lines 2..0 toggle, so a stale level never passes; line 3 keeps its level.
	task automatic clk1(input logic [3:0] d, input logic [3:0] m);
		o_sclk = 1'b0;
		o_io[2:0] = (d[2:0] & m[2:0]) | (~o_io[2:0] & ~m[2:0]);
		if (m[3])
			o_io[3] = d[3];
		#16 o_sclk = 1'b1;
		rd_byte = {rd_byte[6:0], i_io[1]};
		#16;
	endtask : clk1

	task automatic send(input logic [7:0] val, input int lanes);
		logic [7:0] v;
		v = val;
		for (int k = 0; k < 8 / lanes; k++) begin
			clk1(v[7:4] >> (4 - lanes), 4'hF >> (4 - lanes));
			v = v << lanes;
		end
	endtask : send

	task automatic tick(input int n);
		repeat (n) clk1(4'h0, 4'h0);
	endtask : tick

	task automatic frame_start(input logic mode3);
		idle_hi = mode3;
		o_sclk = mode3;
		// Odd offsets keep link edges off the system clock edges.
		#5 o_cs_n = 1'b0;
		#11;
	endtask : frame_start

	// The pause pin is released only once select is high again.
	task automatic frame_end();
		if (!idle_hi)
			o_sclk = 1'b0;
		#16 o_cs_n = 1'b1;
		o_io[3] = 1'b1;
		#40;
	endtask : frame_end
endmodule : sfb_host_model

//--- sfb_front_end_tb.sv
// Self-checking bench for the serial flash front end with a host model.
// Assumes the checker and host model are compiled before this file.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module sfb_front_end_tb;
	localparam int RST_CYC = 4;
	logic clk_sys = 1'b0;
	logic rstn, sclk, cs_n, rst_pin_n, qe, sel, tx_valid, tx_ready;
	logic rx_valid, qmode, hw_rst;
	logic [3:0] host_io, io_in, io_out, io_oe;
	logic [7:0] tx_byte, b;
	logic [23:0] addr;
	sfb_pkg::sfb_rx_s rx;
	sfb_pkg::sfb_rx_s rx_last = '0;
	int error_cnt = 0;
	int total_checks = 0;

	always #4 clk_sys = ~clk_sys;
	assign io_in = (io_oe & io_out) | (~io_oe & host_io);

	sfb_front_end #(.RST_CYC(RST_CYC)) sfb_front_end_inst (.i_clk_sys(clk_sys),
		.i_rstn(rstn), .i_sclk(sclk), .i_cs_n(cs_n), .i_io_in(io_in),
		.o_io_out(io_out), .o_io_oe(io_oe), .i_rst_pin_n(rst_pin_n),
		.i_quad_enable_bit(qe), .i_pin_func_sel(sel), .i_tx_byte(tx_byte),
		.i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx(rx),
		.o_rx_valid(rx_valid), .o_four_line_command_mode(qmode),
		.o_hw_reset(hw_rst));
	sfb_host_model sfb_host_model_inst (.o_sclk(sclk), .o_cs_n(cs_n),
		.o_io(host_io), .i_io(io_in));

	always @(posedge clk_sys)
		if (rx_valid === 1'b1)
			rx_last <= rx;

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cycles

	task automatic tx(input logic [7:0] v, input int l);
		sfb_host_model_inst.send(v, l);
	endtask : tx

	task automatic fs(input logic m3);
		sfb_host_model_inst.frame_start(m3);
	endtask : fs

	task automatic fe();
		sfb_host_model_inst.frame_end();
	endtask : fe

	task automatic pin(input logic v);
		sfb_host_model_inst.o_io[3] = v;
	endtask : pin

	task automatic cfg(input logic q, input logic s);
		cycles(1);
		qe = q;
		sel = s;
	endtask : cfg

	task automatic load_tx(input logic [7:0] v);
		cycles(1);
		tx_byte = v;
		tx_valid = 1'b1;
		for (int i = 0; i < 40 && tx_ready !== 1'b1; i++)
			cycles(1);
		cycles(1);
		tx_valid = 1'b0;
	endtask : load_tx

	// Status is read first, as a host does before each new command.
	task automatic rd_status(input logic m3);
		b = 8'($urandom);
		load_tx(b);
		fs(m3);
		tx(sfb_pkg::OP_RDSR1, 1);
		tx(8'h00, 1);
		`CHK(sfb_host_model_inst.rd_byte, b)
		`CHK(io_oe, 4'h2)
		`CHK(rx_last, {sfb_pkg::RX_OPCODE, 16'h0000, sfb_pkg::OP_RDSR1})
		tx(8'h00, 1);
		`CHK(sfb_host_model_inst.rd_byte, 8'hFF)
		fe();
		`CHK(io_oe, 4'h0)
	endtask : rd_status

	task automatic reject(input logic [7:0] op);
		fs(1'b0);
		tx(op, 1);
		tx(8'h00, 1);
		tx(8'h00, 1);
		`CHK(io_oe, 4'h0)
		fe();
		`CHK(qmode, 1'b0)
	endtask : reject

	task automatic lanes(input logic [7:0] op, input int al, input int dm,
		input logic [3:0] exp);
		addr = 24'($urandom);
		fs(1'b0);
		tx(op, 1);
		for (int i = 2; i >= 0; i--)
			tx(addr[i * 8 +: 8], al);
		sfb_host_model_inst.tick(dm);
		tx(8'h00, 1);
		`CHK(io_oe, exp)
		`CHK(rx_last, {sfb_pkg::RX_ADDR, addr})
		fe();
	endtask : lanes

	task automatic one_op(input logic [7:0] op, input int l);
		fs(1'b0);
		tx(op, l);
		fe();
		cycles(8);
	endtask : one_op

	initial begin
		#400000;
		error_cnt++;
		summarize();
	end

	initial begin
		rstn = 1'b0;
		rst_pin_n = 1'b1;
		qe = 1'b0;
		sel = 1'b0;
		tx_byte = 8'h00;
		tx_valid = 1'b0;
		void'($urandom(32'hFD73A10C));
		cycles(4);
		rstn = 1'b1;
		cycles(4);
		`CHK(qmode, 1'b0)
		`CHK(hw_rst, 1'b0)
		$display("test reset done");
		fs(1'b0);
		tx(8'hFF, 2);
		fe();
		rd_status(1'b0);
		rd_status(1'b1);
		$display("test single line done");
		reject(8'hA5);
		reject(sfb_pkg::OP_QUAD_IO);
		reject(sfb_pkg::OP_QPI_ON);
		$display("test refusal done");
		cfg(1'b1, 1'b0);
		lanes(sfb_pkg::OP_FAST, 1, 8, 4'h2);
		lanes(sfb_pkg::OP_DUAL_OUT, 1, 8, 4'h3);
		lanes(sfb_pkg::OP_DUAL_IO, 2, 4, 4'h3);
		lanes(sfb_pkg::OP_QUAD_OUT, 1, 8, 4'hF);
		lanes(sfb_pkg::OP_QUAD_IO, 4, 6, 4'hF);
		b = 8'($urandom);
		fs(1'b0);
		tx(sfb_pkg::OP_QUAD_PROG, 1);
		tx(8'h00, 1);
		tx(8'h01, 1);
		tx(8'h02, 1);
		tx(b, 4);
		cycles(6);
		`CHK(rx_last, {sfb_pkg::RX_DATA, 16'h0000, b})
		fe();
		$display("test lanes done");
		one_op(sfb_pkg::OP_QPI_ON, 1);
		`CHK(qmode, 1'b1)
		one_op(sfb_pkg::OP_QPI_OFF, 4);
		`CHK(qmode, 1'b0)
		`CHK(rx_last, {sfb_pkg::RX_OPCODE, 16'h0000, 8'hFF})
		one_op(sfb_pkg::OP_QPI_ON, 1);
		one_op(sfb_pkg::OP_RST, 4);
		`CHK(qmode, 1'b0)
		$display("test four-line mode done");
		cfg(1'b0, 1'b0);
		b = 8'($urandom);
		load_tx(b);
		fs(1'b0);
		tx(sfb_pkg::OP_RDSR1, 1);
		pin(1'b0);
		tx(8'h00, 1);
		`CHK(io_oe, 4'h0)
		pin(1'b1);
		tx(8'h00, 1);
		`CHK(io_oe, 4'h2)
		`CHK(sfb_host_model_inst.rd_byte, b)
		pin(1'b0);
		fe();
		rd_status(1'b0);
		$display("test pause done");
		cfg(1'b0, 1'b1);
		pin(1'b0);
		cycles(RST_CYC + 10);
		`CHK(hw_rst, 1'b1)
		pin(1'b1);
		cycles(6);
		`CHK(hw_rst, 1'b0)
		cfg(1'b1, 1'b1);
		one_op(sfb_pkg::OP_QPI_ON, 1);
		pin(1'b0);
		cycles(RST_CYC + 10);
		`CHK(hw_rst, 1'b0)
		pin(1'b1);
		rst_pin_n = 1'b0;
		cycles(RST_CYC + 10);
		`CHK(hw_rst, 1'b1)
		`CHK(qmode, 1'b0)
		rst_pin_n = 1'b1;
		cycles(6);
		`CHK(hw_rst, 1'b0)
		$display("test pin reset done");
		summarize();
	end
endmodule : sfb_front_end_tb
